// ### rtl/epm_pkg.sv
// Package: constants, register map and carrier types of the EEPROM pin mux
package epm_pkg;

   // ******************************
   // Register map (byte addresses)
   // ******************************
   localparam logic [7:0] EPM_REG_PIN_ROLE = 8'h00;
   localparam logic [7:0] EPM_REG_GPO = 8'h04;
   localparam logic [7:0] EPM_REG_PHY_CTRL = 8'h08;
   localparam logic [7:0] EPM_REG_STATUS = 8'h0c;

   // Field positions
   localparam int EPM_ROLE_DATA_LSB = 0;
   localparam int EPM_ROLE_CLK_LSB = 2;
   localparam int EPM_GPO_THREE_BIT = 0;
   localparam int EPM_GPO_FOUR_BIT = 1;
   localparam int EPM_PHY_MANUAL_REV_BIT = 0;
   localparam int EPM_ST_BUS32_BIT = 0;
   localparam int EPM_ST_AUTOX_BIT = 1;
   localparam int EPM_ST_REVERSED_BIT = 2;
   localparam int EPM_ST_READ_SEEN_BIT = 3;
   localparam int EPM_ST_CS_BLOCKED_BIT = 4;
   localparam int EPM_ST_REF_LOST_BIT = 5;

   // ******************************
   // Timing
   // ******************************
   localparam int EPM_CLOCK_PERIOD_NS = 25;
   localparam int EPM_REF_FREQ_MHZ = 25;
   localparam int EPM_REF_PERIOD_NS = 1000 / EPM_REF_FREQ_MHZ;
   // Four reference periods without an edge means the reference stopped
   localparam int EPM_REF_TIMEOUT_NS = 4 * EPM_REF_PERIOD_NS;
   localparam int EPM_REF_TIMEOUT_CYC =
      (EPM_REF_TIMEOUT_NS + EPM_CLOCK_PERIOD_NS - 1) / EPM_CLOCK_PERIOD_NS;
   localparam logic [3:0] EPM_REF_TIMEOUT = 4'(EPM_REF_TIMEOUT_CYC);

   // ******************************
   // Types
   // ******************************
   typedef enum logic [1:0] {
      EPM_ROLE_NVM = 2'b00,
      EPM_ROLE_GPO = 2'b01,
      EPM_ROLE_MON_CTL = 2'b10,
      EPM_ROLE_MON_CLK = 2'b11
   } epm_role_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } epm_bus_req_t;

   typedef struct packed {
      logic p;
      logic n;
   } epm_diff_t;

   typedef struct packed {
      logic a_p;
      logic a_n;
      logic b_p;
      logic b_n;
   } epm_pair_t;

   typedef struct packed {
      logic cs;
      logic sclk;
      logic dout;
      logic doe;
   } epm_nvm_ctrl_t;

   typedef struct packed {
      logic tx_en;
      logic tx_clk;
      logic rx_dv;
      logic rx_clk;
   } epm_mii_mon_t;

   typedef struct packed {
      epm_role_t data_role;
      epm_role_t clk_role;
      logic gpo_three;
      logic gpo_four;
      logic manual_rev;
      logic read_seen;
      logic strap_pending;
      logic bus32;
      logic [31:0] rdata;
      logic data_o;
      logic data_oe;
      logic clk_o;
      logic cs_o;
      logic nvm_di;
      logic xtal_o;
      logic ref_prev;
      logic [3:0] ref_idle;
      logic ref_lost;
   } epm_state_t;

   localparam epm_state_t EPM_STATE_RESET = '{
      data_role: EPM_ROLE_NVM,
      clk_role: EPM_ROLE_NVM,
      strap_pending: 1'b1,
      default: '0
   };

endpackage

// ### rtl/epm_pair_swap.sv
// Twisted-pair direction swap between the PHY core and the pair pins
`timescale 1ns/10ps
module epm_pair_swap
   import epm_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sync_rst,
   input wire logic reverse,
   input wire epm_diff_t tx,
   output epm_diff_t rx,
   input wire epm_pair_t pin_in,
   output epm_pair_t pin_out,
   output epm_pair_t pin_oe
);

   typedef struct packed {
      epm_diff_t rx;
      epm_pair_t out;
      epm_pair_t oe;
   } epm_swap_state_t;

   epm_swap_state_t s;
   epm_swap_state_t next_s;

   always_comb begin
      next_s = s;
      if (reverse) begin
         // Pair A listens, pair B drives
         next_s.out = '{a_p: 1'b0, a_n: 1'b0, b_p: tx.p, b_n: tx.n};
         next_s.oe = '{a_p: 1'b0, a_n: 1'b0, b_p: 1'b1, b_n: 1'b1};
         next_s.rx = '{p: pin_in.a_p, n: pin_in.a_n};
      end else begin
         next_s.out = '{a_p: tx.p, a_n: tx.n, b_p: 1'b0, b_n: 1'b0};
         next_s.oe = '{a_p: 1'b1, a_n: 1'b1, b_p: 1'b0, b_n: 1'b0};
         next_s.rx = '{p: pin_in.b_p, n: pin_in.b_n};
      end
      if (sync_rst) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rx = s.rx;
   assign pin_out = s.out;
   assign pin_oe = s.oe;

endmodule

// ### rtl/epm_pin_mux.sv
// Shared EEPROM pin roles, bus-width strap, crossover and reset control
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module epm_pin_mux
   import epm_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic EXTERNAL_RESET_N,
   input wire logic POWER_SAVE_EXIT,
   input wire epm_bus_req_t REG_REQ,
   output logic [31:0] REG_RDATA,
   input wire logic REFERENCE_CLOCK_IN,
   output logic CRYSTAL_DRIVE_OUT,
   output logic REFERENCE_LOST,
   input wire logic CROSSOVER_ENABLE_STRAP,
   input wire logic CABLE_REVERSED,
   input wire epm_diff_t PHY_TX,
   output epm_diff_t PHY_RX,
   input wire epm_pair_t PAIR_IN,
   output epm_pair_t PAIR_OUT,
   output epm_pair_t PAIR_OE,
   input wire epm_nvm_ctrl_t NVM_CTRL,
   output logic NVM_READ_DATA,
   input wire logic NVM_DATA_PIN_IN,
   output logic NVM_DATA_PIN_OUT,
   output logic NVM_DATA_PIN_OE,
   output logic NVM_SERIAL_CLOCK,
   output logic NVM_CHIP_SELECT,
   input wire epm_mii_mon_t MII_MON,
   output logic BUS_WIDTH_32
);

   // ******************************
   // Helpers
   // ******************************

   // Output level of a shared pin for its role; every code but NVM is an output
   // role, and in NVM the data pin is an input while NVM_CTRL.doe is low
   function automatic logic role_level(
      input epm_role_t role,
      input logic nvm,
      input logic gpo,
      input logic mon_ctl,
      input logic mon_clk
   );
      logic lvl;
      lvl = nvm;
      unique case (role)
         EPM_ROLE_NVM: lvl = nvm;
         EPM_ROLE_GPO: lvl = gpo;
         EPM_ROLE_MON_CTL: lvl = mon_ctl;
         EPM_ROLE_MON_CLK: lvl = mon_clk;
      endcase
      return lvl;
   endfunction

   function automatic logic [31:0] bit_at(input int pos, input logic v);
      logic [31:0] w;
      w = '0;
      w[pos] = v;
      return w;
   endfunction

   // ******************************
   // State
   // ******************************
   epm_state_t s;
   epm_state_t next_s;
   logic sync_rst;
   logic auto_cross;
   logic reversed;
   logic both_nvm;
   logic ref_edge;

   // Power-on reset arrives on RST; the pin reset acts on the clock
   assign sync_rst = !EXTERNAL_RESET_N;
   assign auto_cross = CROSSOVER_ENABLE_STRAP;
   assign reversed = (auto_cross && CABLE_REVERSED) || s.manual_rev;
   assign both_nvm = (s.data_role == EPM_ROLE_NVM)
      && (s.clk_role == EPM_ROLE_NVM);
   assign ref_edge = REFERENCE_CLOCK_IN != s.ref_prev;

   always_comb begin
      next_s = s;
      next_s.rdata = '0;

      // ******************************
      // Bus-width strap
      // ******************************
      // The data pin is left undriven while the strap is pending so the
      // board pull can be read in the first cycle after release
      if (s.strap_pending) begin
         next_s.bus32 = NVM_DATA_PIN_IN;
         next_s.strap_pending = 1'b0;
      end

      // ******************************
      // Register access
      // ******************************
      if (POWER_SAVE_EXIT) begin
         next_s.read_seen = 1'b0;
      end
      if (REG_REQ.rd) begin
         next_s.read_seen = 1'b1;
         unique case (REG_REQ.addr)
            EPM_REG_PIN_ROLE:
               next_s.rdata = 32'(s.data_role) << EPM_ROLE_DATA_LSB
                  | 32'(s.clk_role) << EPM_ROLE_CLK_LSB;
            EPM_REG_GPO:
               next_s.rdata = bit_at(EPM_GPO_THREE_BIT, s.gpo_three)
                  | bit_at(EPM_GPO_FOUR_BIT, s.gpo_four);
            EPM_REG_PHY_CTRL:
               next_s.rdata = bit_at(EPM_PHY_MANUAL_REV_BIT, s.manual_rev);
            EPM_REG_STATUS:
               next_s.rdata = bit_at(EPM_ST_BUS32_BIT, s.bus32)
                  | bit_at(EPM_ST_AUTOX_BIT, auto_cross)
                  | bit_at(EPM_ST_REVERSED_BIT, reversed)
                  | bit_at(EPM_ST_READ_SEEN_BIT, s.read_seen)
                  | bit_at(EPM_ST_CS_BLOCKED_BIT, !both_nvm)
                  | bit_at(EPM_ST_REF_LOST_BIT, s.ref_lost);
            default: next_s.rdata = '0;
         endcase
      end
      // Writes before the first read after reset or POWER_SAVE_EXIT are dropped silently
      if (REG_REQ.wr && s.read_seen) begin
         unique case (REG_REQ.addr)
            EPM_REG_PIN_ROLE: begin
               next_s.data_role = epm_role_t'(
                  REG_REQ.wdata[EPM_ROLE_DATA_LSB +: 2]);
               next_s.clk_role = epm_role_t'(
                  REG_REQ.wdata[EPM_ROLE_CLK_LSB +: 2]);
            end
            EPM_REG_GPO: begin
               next_s.gpo_three = REG_REQ.wdata[EPM_GPO_THREE_BIT];
               next_s.gpo_four = REG_REQ.wdata[EPM_GPO_FOUR_BIT];
            end
            EPM_REG_PHY_CTRL:
               next_s.manual_rev = REG_REQ.wdata[EPM_PHY_MANUAL_REV_BIT];
            default: begin
            end
         endcase
      end

      // ******************************
      // Shared pins
      // ******************************
      // Monitors are sampled on CLOCK, so a monitored MII clock is only a
      // coarse image of the real one; edges may move by one period
      next_s.data_o = role_level(s.data_role, NVM_CTRL.dout, s.gpo_three,
         MII_MON.tx_en, MII_MON.tx_clk);
      if (s.data_role == EPM_ROLE_NVM) begin
         next_s.data_oe = NVM_CTRL.doe && !s.strap_pending;
      end else begin
         next_s.data_oe = !s.strap_pending;
      end
      next_s.nvm_di = (s.data_role == EPM_ROLE_NVM) && NVM_DATA_PIN_IN;
      next_s.clk_o = role_level(s.clk_role, NVM_CTRL.sclk, s.gpo_four,
         MII_MON.rx_dv, MII_MON.rx_clk);
      next_s.cs_o = NVM_CTRL.cs && both_nvm;

      // ******************************
      // Reference clock
      // ******************************
      next_s.xtal_o = !REFERENCE_CLOCK_IN;
      next_s.ref_prev = REFERENCE_CLOCK_IN;
      if (ref_edge) begin
         next_s.ref_idle = '0;
         next_s.ref_lost = 1'b0;
      end else if (s.ref_idle == EPM_REF_TIMEOUT) begin
         next_s.ref_lost = 1'b1;
      end else begin
         next_s.ref_idle = s.ref_idle + 4'h1;
      end

      if (sync_rst) begin
         next_s = EPM_STATE_RESET;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s <= EPM_STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ******************************
   // Twisted pair
   // ******************************
   epm_pair_swap u_swap (
      .clock(CLOCK),
      .rst(RST),
      .sync_rst(sync_rst),
      .reverse(reversed),
      .tx(PHY_TX),
      .rx(PHY_RX),
      .pin_in(PAIR_IN),
      .pin_out(PAIR_OUT),
      .pin_oe(PAIR_OE)
   );

   assign REG_RDATA = s.rdata;
   assign CRYSTAL_DRIVE_OUT = s.xtal_o;
   assign REFERENCE_LOST = s.ref_lost;
   assign NVM_READ_DATA = s.nvm_di;
   assign NVM_DATA_PIN_OUT = s.data_o;
   assign NVM_DATA_PIN_OE = s.data_oe;
   assign NVM_SERIAL_CLOCK = s.clk_o;
   assign NVM_CHIP_SELECT = s.cs_o;
   assign BUS_WIDTH_32 = s.bus32;

endmodule

// ### tb/epm_pin_mux_chk.sv
// Port checker of the EEPROM pin mux
`timescale 1ns/10ps
module epm_pin_mux_chk
   import epm_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic EXTERNAL_RESET_N,
   input wire epm_bus_req_t REG_REQ,
   input wire logic [31:0] REG_RDATA,
   input wire logic REFERENCE_CLOCK_IN,
   input wire logic CRYSTAL_DRIVE_OUT,
   input wire logic CROSSOVER_ENABLE_STRAP,
   input wire logic CABLE_REVERSED,
   input wire epm_diff_t PHY_TX,
   input wire epm_diff_t PHY_RX,
   input wire epm_pair_t PAIR_IN,
   input wire epm_pair_t PAIR_OUT,
   input wire epm_pair_t PAIR_OE,
   input wire epm_nvm_ctrl_t NVM_CTRL,
   input wire logic NVM_DATA_PIN_IN,
   input wire logic NVM_DATA_PIN_OE,
   input wire logic NVM_CHIP_SELECT,
   input wire logic BUS_WIDTH_32
);
   // *****
   // Properties
   // *****
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   // Reset values still show on the first edge after any release
   sequence live;
      !$past(RST) && $past(EXTERNAL_RESET_N);
   endsequence
   cs_follow_a: assert property (
      NVM_CHIP_SELECT |-> $past(NVM_CTRL.cs))
      else $error("chip select without engine request");
   cs_block_a: assert property (NVM_DATA_PIN_OE && !$past(NVM_CTRL.doe)
      |-> !NVM_CHIP_SELECT) else $error("chip select while pin reassigned");
   rdata_idle_a: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == '0)
      else $error("read data outside answer cycle");
   xtal_inv_a: assert property (live |->
      CRYSTAL_DRIVE_OUT == !$past(REFERENCE_CLOCK_IN))
      else $error("crystal drive not inverse of reference");
   ext_reset_a: assert property (!EXTERNAL_RESET_N |=> !NVM_CHIP_SELECT
      && !BUS_WIDTH_32 && PAIR_OE == '0 && REG_RDATA == '0)
      else $error("external reset left state behind");
   strap_latch_a: assert property ($rose(EXTERNAL_RESET_N) |=>
      BUS_WIDTH_32 == $past(NVM_DATA_PIN_IN)) else $error("strap not caught");
   strap_hold_a: assert property ($past(EXTERNAL_RESET_N, 2) &&
      $past(EXTERNAL_RESET_N) && !$past(RST, 2) && !$past(RST)
      |-> $stable(BUS_WIDTH_32)) else $error("bus width changed in run");
   xover_dir_a: assert property (live ##0
      $past(CROSSOVER_ENABLE_STRAP && CABLE_REVERSED) |-> PAIR_OE == 4'b0011)
      else $error("auto crossover did not reverse");
   route_norm_a: assert property (PAIR_OE == 4'b1100 |->
      {PAIR_OUT.a_p, PAIR_OUT.a_n} == $past(PHY_TX) &&
      PHY_RX == {$past(PAIR_IN.b_p), $past(PAIR_IN.b_n)})
      else $error("normal pair routing wrong");
   route_rev_a: assert property (PAIR_OE == 4'b0011 |->
      {PAIR_OUT.b_p, PAIR_OUT.b_n} == $past(PHY_TX) &&
      PHY_RX == {$past(PAIR_IN.a_p), $past(PAIR_IN.a_n)})
      else $error("reversed pair routing wrong");
   cover property (NVM_CHIP_SELECT);
   cover property ($rose(EXTERNAL_RESET_N));
   cover property (PAIR_OE == 4'b0011);
endmodule

// ### tb/epm_nvm_model.sv
// Serial EEPROM and board strap pull on the shared data pin
`timescale 1ns/10ps
module epm_nvm_model (
   input wire logic cs,
   input wire logic sclk,
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic strap,
   output logic dio
);
   logic ans = 1'b0;
   // Answer flips on each clock rise with cs high and dev_out low so a stale sample is seen
   always @(posedge sclk) begin
      if (cs) begin
         ans <= ~ans ^ dev_out;
      end
   end
   // Strap resistor sets the level whenever nobody drives
   assign dio = dev_oe ? dev_out : (cs ? ans : strap);
endmodule

// ### tb/test_epm_pin_mux.sv
// Self-checking bench of the EEPROM pin mux
`timescale 1ns/10ps
module test_epm_pin_mux
   import epm_pkg::*;
;
   logic clock = 1'b0, rst = 1'b1, ext_n = 1'b1, ps_exit = 1'b0;
   logic ref_clk = 1'b0, ref_run = 1'b1, xstrap = 1'b0, rev = 1'b0;
   logic strap = 1'b0, pin_in, xtal, ref_lost, nvm_rd, pin_out, pin_oe;
   logic sclk, cs, bus32;
   logic [31:0] rdata, rnd;
   epm_bus_req_t req = '0;
   epm_diff_t phy_tx = '0, phy_rx;
   epm_pair_t pair_in = '0, pair_out, pair_oe;
   epm_nvm_ctrl_t nvm_ctrl = '0;
   epm_mii_mon_t mii = '0;
   int seed = 32'h8a1ae27b, n_fail = 0, n_checks = 0;
   epm_pin_mux epm_pin_mux_inst (.CLOCK(clock), .RST(rst),
      .EXTERNAL_RESET_N(ext_n), .POWER_SAVE_EXIT(ps_exit), .REG_REQ(req),
      .REG_RDATA(rdata), .REFERENCE_CLOCK_IN(ref_clk),
      .CRYSTAL_DRIVE_OUT(xtal), .REFERENCE_LOST(ref_lost),
      .CROSSOVER_ENABLE_STRAP(xstrap), .CABLE_REVERSED(rev), .PHY_TX(phy_tx),
      .PHY_RX(phy_rx), .PAIR_IN(pair_in), .PAIR_OUT(pair_out),
      .PAIR_OE(pair_oe), .NVM_CTRL(nvm_ctrl), .NVM_READ_DATA(nvm_rd),
      .NVM_DATA_PIN_IN(pin_in), .NVM_DATA_PIN_OUT(pin_out),
      .NVM_DATA_PIN_OE(pin_oe), .NVM_SERIAL_CLOCK(sclk),
      .NVM_CHIP_SELECT(cs), .MII_MON(mii), .BUS_WIDTH_32(bus32));
   epm_nvm_model epm_nvm_model_inst (.cs(cs), .sclk(sclk), .dev_out(pin_out),
      .dev_oe(pin_oe), .strap(strap), .dio(pin_in));
   // *****
   // Clocks and random traffic
   // *****
   initial forever #12.5 clock = ~clock;
   initial forever #20 ref_clk = ref_run ? ~ref_clk : ref_clk;
   always @(posedge clock) begin
      rnd = $random(seed);
      mii <= rnd[3:0];
      phy_tx <= rnd[5:4];
      pair_in <= rnd[9:6];
      nvm_ctrl <= rnd[13:10];
      rev <= rnd[14];
      xstrap <= rnd[15];
   end
   // *****
   // Helpers
   // *****
   task automatic chk(input string name, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) req <= {1'b0, 1'b1, a, d};
      @(posedge clock) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, m);
      @(posedge clock) req <= {1'b1, 1'b0, a, 32'h0};
      @(posedge clock) req <= '0;
      #1 chk("read data", exp, rdata & m);
   endtask
   task automatic ext_reset(input logic s);
      @(posedge clock) ext_n <= 1'b0;
      strap <= s;
      repeat (2) @(posedge clock);
      ext_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk("bus width", 32'(s), 32'(bus32));
   endtask
   // Expected {data out, data enable, clock pin, chip select, read data}
   function automatic logic [4:0] expect_pins(epm_role_t dr, cr,
      logic [1:0] g);
      logic [3:0] d;
      logic [3:0] c;
      d = {mii.tx_clk, mii.tx_en, g[0], nvm_ctrl.dout};
      c = {mii.rx_clk, mii.rx_dv, g[1], nvm_ctrl.sclk};
      return {d[dr], dr == EPM_ROLE_NVM ? nvm_ctrl.doe : 1'b1, c[cr],
         nvm_ctrl.cs && dr == EPM_ROLE_NVM && cr == EPM_ROLE_NVM,
         dr == EPM_ROLE_NVM && pin_in};
   endfunction
   task automatic pins(input epm_role_t dr, cr);
      logic [4:0] exp;
      logic [1:0] g;
      g = 2'($random(seed));
      wr(EPM_REG_GPO, {30'h0, g});
      wr(EPM_REG_PIN_ROLE, {28'h0, cr, dr});
      repeat (2) @(posedge clock);
      repeat (4) begin
         @(negedge clock) exp = expect_pins(dr, cr, g);
         @(negedge clock) chk("pins", 32'(exp),
            32'({pin_out, pin_oe, sclk, cs, nvm_rd}));
      end
   endtask
   task automatic test_done;
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // *****
   // Scenarios
   // *****
   initial begin
      #2000000;
      n_fail++;
      test_done;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      wr(EPM_REG_PIN_ROLE, 32'hf);
      rd(EPM_REG_PIN_ROLE, 32'h0, 32'hf);
      rd(EPM_REG_STATUS, 32'h8, 32'h9);
      wr(EPM_REG_PIN_ROLE, 32'h9);
      rd(EPM_REG_PIN_ROLE, 32'h9, 32'hf);
      rd(8'h10, 32'h0, 32'hffffffff);
      @(posedge clock) ps_exit <= 1'b1;
      @(posedge clock) ps_exit <= 1'b0;
      wr(EPM_REG_PIN_ROLE, 32'h0);
      rd(EPM_REG_PIN_ROLE, 32'h9, 32'hf);
      for (int i = 0; i < 16; i++) begin
         pins(epm_role_t'(i[1:0]), epm_role_t'(i[3:2]));
      end
      wr(EPM_REG_PHY_CTRL, 32'h1);
      repeat (2) @(posedge clock);
      repeat (4) begin
         @(negedge clock) chk("pair enable", 32'h3, 32'(pair_oe));
      end
      rd(EPM_REG_STATUS, 32'h4, 32'h4);
      wr(EPM_REG_PHY_CTRL, 32'h0);
      ext_reset(1'b1);
      rd(EPM_REG_PIN_ROLE, 32'h0, 32'hf);
      rd(EPM_REG_STATUS, 32'h9, 32'h9);
      ext_reset(1'b0);
      ref_run = 1'b0;
      repeat (12) @(posedge clock);
      #1 chk("reference lost", 32'h1, 32'(ref_lost));
      ref_run = 1'b1;
      repeat (12) @(posedge clock);
      #1 chk("reference lost", 32'h0, 32'(ref_lost));
      test_done;
   end
endmodule
bind epm_pin_mux epm_pin_mux_chk epm_pin_mux_chk_inst (.CLOCK, .RST,
   .EXTERNAL_RESET_N, .REG_REQ, .REG_RDATA, .REFERENCE_CLOCK_IN,
   .CRYSTAL_DRIVE_OUT, .CROSSOVER_ENABLE_STRAP, .CABLE_REVERSED, .PHY_TX,
   .PHY_RX, .PAIR_IN, .PAIR_OUT, .PAIR_OE, .NVM_CTRL, .NVM_DATA_PIN_IN,
   .NVM_DATA_PIN_OE, .NVM_CHIP_SELECT, .BUS_WIDTH_32);
